// File: verilog/apo_pkg.sv
// Purpose: constants for the alarm protection output block
// Assumes: 16-bit register port, word offsets as printed
// Notes: alarm vector bit n matches mask weight 2**n
package apo_pkg;
    localparam logic [7:0] APO_OFF_CONFIG = 8'h11;
    localparam logic [7:0] APO_OFF_STATUS = 8'h26;
    localparam logic [7:0] APO_OFF_IRQ_STAT = 8'h40;
    localparam logic [7:0] APO_OFF_IRQ_MASK = 8'h41;
    localparam logic [7:0] APO_OFF_CTRL = 8'h42;
    localparam logic [7:0] APO_OFF_TIME_LO = 8'h43;
    localparam logic [7:0] APO_OFF_TIME_HI = 8'h44;
    localparam logic [7:0] APO_OFF_REC_LO = 8'h45;
    localparam logic [7:0] APO_OFF_REC_HI = 8'h46;
    localparam logic [7:0] APO_OFF_STORED = 8'h47;
    localparam int APO_DELAY_LSB = 12;
    localparam int APO_DELAY_W = 4;
    localparam int APO_HEALTHY_BIT = 11;
    localparam logic [15:0] APO_MASK_VALID = 16'h00fe;
    localparam logic [15:0] APO_STORE_MASK = 16'h009e;
    localparam logic [15:0] APO_CONFIG_RST = 16'h0000;
    localparam logic [15:0] APO_CTRL_RST = 16'h0001;
    localparam int APO_CTRL_POL_BIT = 0;
    localparam int APO_CTRL_REVOK_BIT = 1;
    localparam int APO_CLK_HZ = 100_000_000;
    localparam int APO_SEC_MS = 1000;
    localparam int APO_TICK_CYCLES = APO_CLK_HZ / 1000 * APO_SEC_MS;
    localparam int APO_TICK_W = 27;
    localparam logic [2:0] APO_IRQ_RST = 3'h0;
    localparam int APO_IRQ_ALARM = 0;
    localparam int APO_IRQ_OUT = 1;
    localparam int APO_IRQ_CLEAR = 2;
    typedef enum logic [1:0] {
        APO_ST_IDLE = 2'b00,
        APO_ST_WAIT = 2'b01,
        APO_ST_TRIP = 2'b11
    } apo_state_t;
endpackage

// File: verilog/apo_tick.sv
// Purpose: one-second timebase pulse generator
// Assumes: clk at 100 MHz
// Notes: restart realigns the second so a delay counts full seconds
`timescale 1ns/100ps
module apo_tick import apo_pkg::*; #(
    parameter int TICK_CYCLES = APO_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic restart,
    output logic tick
);
    logic [APO_TICK_W-1:0] cnt_q;
    logic [APO_TICK_W-1:0] cnt_d;
    logic tick_d;
    logic tick_q;

    always_comb begin
        tick_d = 1'b0;
        if (restart) begin
            cnt_d = '0;
        end else if (cnt_q == APO_TICK_W'(TICK_CYCLES - 1)) begin
            cnt_d = '0;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q & clk_en;
endmodule

// File: verilog/apo_ctrl.sv
// Purpose: alarm driven protection output and healthy status
// Assumes: alarm inputs are asynchronous levels from detection logic
// Notes: open-collector output: conduct high means transistor closed
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
module apo_ctrl import apo_pkg::*; #(
    parameter int TICK_CYCLES = APO_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [15:0] alarm_in,
    input wire logic running,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic protection_output,
    output logic healthy_indicator,
    output logic irq
);
    logic [15:0] alarm_s1_q;
    logic [15:0] alarm_s2_q;
    logic [15:0] config_q, config_d;
    logic [15:0] ctrl_q, ctrl_d;
    logic [2:0] irq_stat_q, irq_stat_d;
    logic [2:0] irq_mask_q, irq_mask_d;
    logic [15:0] rdata_q, rdata_d;
    logic [31:0] time_q, time_d;
    logic [31:0] operation_time_record_q, operation_time_record_d;
    logic [15:0] stored_q, stored_d;
    logic healthy_q, healthy_d;
    logic out_q, out_d;
    apo_state_t state_q, state_d;
    logic [APO_DELAY_W-1:0] secs_q, secs_d;
    logic tick;
    logic sec_tick;
    logic restart;
    logic [15:0] enabled;
    logic any_enabled;
    logic any_alarm;
    logic [APO_DELAY_W-1:0] delay_sec;
    logic invert;
    logic tripped;
    logic [2:0] events;

    // pins come from the detection logic domain
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            alarm_s1_q <= '0;
            alarm_s2_q <= '0;
        end else if (clk_en) begin
            alarm_s1_q <= alarm_in;
            alarm_s2_q <= alarm_s1_q;
        end
    end

    assign enabled = alarm_s2_q & config_q & APO_MASK_VALID;
    // bit 0 and high mask bits drop out via APO_MASK_VALID
    assign any_enabled = |enabled;
    assign any_alarm = |(alarm_s2_q & APO_MASK_VALID);
    assign delay_sec = config_q[APO_DELAY_LSB +: APO_DELAY_W];
    // either flag clear selects the legacy inverted sense
    assign invert = !(ctrl_q[APO_CTRL_POL_BIT] &
                      ctrl_q[APO_CTRL_REVOK_BIT]);
    assign restart = (state_q == APO_ST_IDLE);

    apo_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .restart(restart),
        .tick(tick)
    );

    // free-running second for the operation time; the delay timebase
    // sits in restart while idle and would never count healthy time
    apo_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_sec (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .restart(1'b0),
        .tick(sec_tick)
    );

    // delay state machine
    always_comb begin
        state_d = state_q;
        secs_d = secs_q;
        case (state_q)
            APO_ST_IDLE: begin
                secs_d = '0;
                if (any_enabled) begin
                    state_d = (delay_sec == '0) ? APO_ST_TRIP
                                                : APO_ST_WAIT;
                end
            end
            APO_ST_WAIT: begin
                if (!any_enabled) begin
                    state_d = APO_ST_IDLE;
                end else if (tick) begin
                    secs_d = secs_q + 1'b1;
                    if (secs_q + 1'b1 >= delay_sec) begin
                        state_d = APO_ST_TRIP;
                    end
                end
            end
            APO_ST_TRIP: begin
                if (!any_enabled) begin
                    state_d = APO_ST_IDLE;
                end
            end
            default: begin
                state_d = APO_ST_IDLE;
            end
        endcase
    end

    assign tripped = (state_d == APO_ST_TRIP);

    // output, health, time and alarm record
    always_comb begin
        out_d = tripped ? invert : !invert;
        healthy_d = running && !any_alarm;
        time_d = time_q;
        if (running && sec_tick) begin
            time_d = time_q + 32'h1;
        end
        operation_time_record_d = operation_time_record_q;
        if (healthy_q && any_alarm) begin
            operation_time_record_d = time_q;
        end
        stored_d = stored_q | (alarm_s2_q & APO_STORE_MASK);
        if (reg_wr && reg_addr == APO_OFF_STORED) begin
            stored_d = (stored_q & ~reg_wdata) |
                       (alarm_s2_q & APO_STORE_MASK);
        end
    end

    // set beats clear on the sticky events
    assign events = {1'b0, out_q != out_d, healthy_q && any_alarm};

    always_comb begin
        config_d = config_q;
        ctrl_d = ctrl_q;
        irq_mask_d = irq_mask_q;
        irq_stat_d = irq_stat_q;
        if (reg_wr) begin
            case (reg_addr)
                APO_OFF_CONFIG: config_d = reg_wdata;
                APO_OFF_CTRL: ctrl_d = reg_wdata & 16'h0003;
                APO_OFF_IRQ_MASK: irq_mask_d = reg_wdata[2:0];
                APO_OFF_IRQ_STAT: irq_stat_d = irq_stat_q & ~reg_wdata[2:0];
                default: ;
            endcase
        end
        irq_stat_d = irq_stat_d | events;
        rdata_d = '0;
        if (reg_rd) begin
            case (reg_addr)
                APO_OFF_CONFIG: rdata_d = config_q;
                APO_OFF_STATUS: rdata_d = 16'(healthy_q) << APO_HEALTHY_BIT;
                APO_OFF_IRQ_STAT: rdata_d = {13'h0, irq_stat_q};
                APO_OFF_IRQ_MASK: rdata_d = {13'h0, irq_mask_q};
                APO_OFF_CTRL: rdata_d = ctrl_q;
                APO_OFF_TIME_LO: rdata_d = time_q[15:0];
                APO_OFF_TIME_HI: rdata_d = time_q[31:16];
                APO_OFF_REC_LO: rdata_d = operation_time_record_q[15:0];
                APO_OFF_REC_HI: rdata_d = operation_time_record_q[31:16];
                APO_OFF_STORED: rdata_d = stored_q;
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= APO_ST_IDLE;
            secs_q <= '0;
            // conducting, the no-alarm level only once both ctrl flags are set; default polarity drops it next cycle
            out_q <= 1'b1;
            healthy_q <= 1'b0;
            time_q <= '0;
            operation_time_record_q <= '0;
            stored_q <= '0;
            config_q <= APO_CONFIG_RST;
            ctrl_q <= APO_CTRL_RST;
            irq_mask_q <= APO_IRQ_RST;
            irq_stat_q <= APO_IRQ_RST;
            rdata_q <= '0;
        end else if (clk_en) begin
            state_q <= state_d;
            secs_q <= secs_d;
            out_q <= out_d;
            healthy_q <= healthy_d;
            time_q <= time_d;
            operation_time_record_q <= operation_time_record_d;
            stored_q <= stored_d;
            config_q <= config_d;
            ctrl_q <= ctrl_d;
            irq_mask_q <= irq_mask_d;
            irq_stat_q <= irq_stat_d;
            rdata_q <= rdata_d;
        end
    end

    assign protection_output = out_q;
    assign healthy_indicator = healthy_q;
    assign reg_rdata = rdata_q;
    assign irq = |(irq_stat_q & irq_mask_q);

    a_normal_closed: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && state_d == APO_ST_IDLE && !invert)
        |=> protection_output)
        else $error("output not conducting in normal state");
    a_zero_delay: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && state_q == APO_ST_IDLE && any_enabled && delay_sec == '0)
        |=> state_q == APO_ST_TRIP)
        else $error("zero delay did not trip at once");
    a_wait_on_tick: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && state_q == APO_ST_WAIT && any_enabled && !tick)
        |=> state_q == APO_ST_WAIT)
        else $error("trip before a second elapsed");
    a_inverted_sense: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && state_d == APO_ST_TRIP && invert)
        |=> protection_output)
        else $error("inverted sense not closed on trip");
    a_masked_alarm: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && state_q == APO_ST_IDLE && !any_enabled)
        |=> state_q == APO_ST_IDLE)
        else $error("disabled alarm left idle");
    a_delay_field: assert property (@(posedge clk) disable iff (!rst_b)
        delay_sec == config_q[15:12])
        else $error("delay field misplaced");
    a_ignored_bits: assert property (@(posedge clk) disable iff (!rst_b)
        (enabled & 16'hff01) == 16'h0)
        else $error("unused mask position acted");
    a_healthy_bit: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && reg_rd && reg_addr == APO_OFF_STATUS)
        |=> reg_rdata[11] == $past(healthy_indicator))
        else $error("status bit 11 mismatch");
    a_record_time: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && healthy_q && any_alarm)
        |=> !healthy_indicator &&
            operation_time_record_q == $past(time_q))
        else $error("alarm did not record time");
    a_no_underspeed: assert property (@(posedge clk) disable iff (!rst_b)
        stored_q[5] == 1'b0)
        else $error("underspeed stored");
    a_cancel_wait: assert property (@(posedge clk) disable iff (!rst_b)
        (clk_en && state_q == APO_ST_WAIT && !any_enabled)
        |=> state_q == APO_ST_IDLE && secs_d == '0)
        else $error("pending change not cancelled");
endmodule

// File: verif/apo_contact_model.sv
// Purpose: outside protection circuit reading the open-collector contact
// Assumes: contact line is pulled up outside the regulator
// Notes: behavioural; the pull-up gives a defined level when off
`timescale 1ns/100ps
module apo_contact_model (
    input wire logic protection_output,
    output logic contact_high
);
    // conducting transistor sinks the pulled-up line
    assign contact_high = protection_output ? 1'b0 : 1'b1;
endmodule

// File: verif/alarm_protection_output_ctrl_tb.sv
// Purpose: register-level test of the alarm protection output block
// Assumes: one-second tick shortened to 10 cycles
// Notes: outputs are sampled on the falling edge, away from updates
`timescale 1ns/100ps
module alarm_protection_output_ctrl_tb import apo_pkg::*;;
    localparam int TICK = 10;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic [15:0] alarm_in = 16'h0000;
    logic running = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic protection_output;
    logic healthy_indicator;
    logic irq;
    logic contact_high;
    logic [15:0] rv;
    int err_count = 0;
    int total_checks = 0;

    always #5 clk = ~clk;

    apo_ctrl #(.TICK_CYCLES(TICK)) DUT (.clk(clk), .rst_b(rst_b),
        .clk_en(clk_en), .alarm_in(alarm_in), .running(running),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .protection_output(protection_output),
        .healthy_indicator(healthy_indicator), .irq(irq));

    apo_contact_model u_contact (.protection_output(protection_output),
        .contact_high(contact_high));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one idle cycle after each access keeps strobes single-assigned
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        rv = reg_rdata;
        @(posedge clk);
    endtask

    // closed transistor reads low at the far side
    task automatic po(input logic e);
        @(negedge clk);
        chk(16'(protection_output), 16'(e));
        chk(16'(contact_high), 16'(!e));
        @(posedge clk);
    endtask

    // settled mid-cycle look at healthy (sel 0) or irq (sel 1)
    task automatic obs(input int sel, input logic [15:0] exp);
        @(negedge clk);
        chk(sel == 0 ? 16'(healthy_indicator) : 16'(irq), exp);
        @(posedge clk);
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #50us;
        err_count++;
        $display("ERROR %0t: watchdog expired", $time);
        final_report;
    end

    initial begin
        cyc(8);
        rst_b <= 1'b1;
        cyc(1);
        rd(APO_OFF_CONFIG);
        chk(rv, APO_CONFIG_RST);
        rd(APO_OFF_CTRL);
        chk(rv, APO_CTRL_RST);
        rd(8'h30);
        chk(rv, 16'h0000);
        po(1'b0);
        wr(APO_OFF_CTRL, 16'h0003);
        running <= 1'b1;
        cyc(30);
        po(1'b1);
        obs(0, 16'h0001);
        rd(APO_OFF_STATUS);
        chk(16'(rv[11]), 16'h0001);
        wr(APO_OFF_IRQ_MASK, 16'h0001);
        wr(APO_OFF_CONFIG, 16'h0002);
        alarm_in <= 16'h0002;
        cyc(5);
        po(1'b0);
        obs(0, 16'h0000);
        obs(1, 16'h0001);
        rd(APO_OFF_STATUS);
        chk(16'(rv[11]), 16'h0000);
        rd(APO_OFF_REC_LO);
        chk(16'(rv !== 16'h0000), 16'h0001);
        alarm_in <= 16'h0000;
        cyc(5);
        po(1'b1);
        wr(APO_OFF_IRQ_STAT, 16'h0007);
        wr(APO_OFF_IRQ_MASK, 16'h0000);
        obs(1, 16'h0000);
        for (int n = 1; n < 8; n++) begin
            wr(APO_OFF_CONFIG, 16'h0001 << n);
            alarm_in <= 16'h0001 << n;
            cyc(5);
            po(1'b0);
            alarm_in <= 16'h00fe & ~(16'h0001 << n);
            cyc(5);
            po(1'b1);
            alarm_in <= 16'h0000;
            cyc(3);
        end
        obs(1, 16'h0000);
        wr(APO_OFF_IRQ_MASK, 16'h0001);
        obs(1, 16'h0001);
        wr(APO_OFF_IRQ_STAT, 16'h0007);
        obs(1, 16'h0000);
        wr(APO_OFF_CONFIG, 16'h0f01);
        alarm_in <= 16'h0f01;
        cyc(5);
        po(1'b1);
        alarm_in <= 16'h0000;
        // longest delay: must not trip early nor late
        wr(APO_OFF_CONFIG, 16'hf002);
        alarm_in <= 16'h0002;
        cyc(150);
        po(1'b1);
        cyc(40);
        po(1'b0);
        alarm_in <= 16'h0000;
        wr(APO_OFF_CONFIG, 16'h2002);
        alarm_in <= 16'h0002;
        cyc(15);
        alarm_in <= 16'h0000;
        cyc(3);
        alarm_in <= 16'h0002;
        cyc(15);
        po(1'b1);
        cyc(15);
        po(1'b0);
        alarm_in <= 16'h0000;
        // let the synchroniser drain, else set beats the clear
        cyc(3);
        wr(APO_OFF_STORED, 16'hffff);
        alarm_in <= 16'h0020;
        cyc(5);
        rd(APO_OFF_STORED);
        chk(rv, 16'h0000);
        alarm_in <= 16'h0000;
        cyc(5);
        alarm_in <= 16'h0002;
        cyc(5);
        rd(APO_OFF_STORED);
        chk(rv, 16'h0002);
        alarm_in <= 16'h0000;
        wr(APO_OFF_CTRL, 16'h0001);
        cyc(3);
        po(1'b0);
        alarm_in <= 16'h0002;
        // config still holds a two-second delay
        cyc(30);
        po(1'b1);
        alarm_in <= 16'h0000;
        final_report;
    end
endmodule
